// >>> hdl/spm_pkg.sv
/*
 * Shared constants and types of the switch port MAC flow-control block.
 * Assumes a 10 MHz system clock; all timing counts derive from that period.
 */
package spm_pkg;

	// ****************************************************************
	// Clock and bit timing
	// ****************************************************************
	localparam int CLK_NS = 100;
	localparam int BIT_NS_100 = 10;
	localparam int BIT_NS_10 = 100;
	localparam int IFG_BITS = 96;
	localparam int SLOT_BITS = 512;
	// Least times, so the cycle counts round up.
	localparam logic [19:0] IFG_CYC_100 = 20'((IFG_BITS * BIT_NS_100 + CLK_NS - 1) / CLK_NS);
	localparam logic [19:0] IFG_CYC_10 = 20'((IFG_BITS * BIT_NS_10 + CLK_NS - 1) / CLK_NS);
	localparam logic [19:0] SLOT_CYC_100 = 20'((SLOT_BITS * BIT_NS_100 + CLK_NS - 1) / CLK_NS);
	localparam logic [19:0] SLOT_CYC_10 = 20'((SLOT_BITS * BIT_NS_10 + CLK_NS - 1) / CLK_NS);
	localparam int STORM_MS_100 = 50;
	localparam int STORM_MS_10 = 500;
	localparam int STORM_CYC_100 = STORM_MS_100 * 1000000 / CLK_NS;
	localparam int STORM_CYC_10 = STORM_MS_10 * 1000000 / CLK_NS;
	localparam int BP_HOLD_US = 2000;
	localparam int BP_HOLD_CYC = BP_HOLD_US * 1000 / CLK_NS;

	// ****************************************************************
	// Frame sizes and field values
	// ****************************************************************
	localparam logic [11:0] MIN_LEN = 12'h040;
	localparam logic [11:0] MAX_STD = 12'h5ee;
	localparam logic [11:0] MAX_1536 = 12'h600;
	localparam logic [11:0] MAX_JUMBO = 12'h800;
	localparam logic [11:0] VLAN_EXTRA = 12'h004;
	localparam logic [11:0] LATE_BYTES = 12'(SLOT_BITS / 8);
	localparam logic [11:0] CTRL_LEN = 12'h040;
	localparam logic [11:0] POS_DA_END = 12'h005;
	localparam logic [11:0] POS_TYPE = 12'h00d;
	localparam logic [11:0] POS_OPCODE = 12'h00f;
	localparam logic [11:0] POS_PTIME = 12'h011;
	localparam logic [7:0] BCAST_BYTE = 8'hff;
	localparam logic [15:0] TYPE_CTRL = 16'h8808;
	localparam logic [15:0] TYPE_VLAN = 16'h8100;
	localparam logic [15:0] OP_PAUSE = 16'h0001;
	localparam logic [15:0] PAUSE_MAX = 16'hffff;
	localparam logic [15:0] PAUSE_ZERO = 16'h0000;

	// ****************************************************************
	// Backoff, storm and reset values
	// ****************************************************************
	localparam logic [4:0] EXCESS_COL = 5'h10;
	localparam logic [4:0] BACKOFF_LIMIT = 5'h0a;
	localparam logic [4:0] AGGR_LIMIT = 5'h03;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [10:0] STORM_LIMIT_RST = 11'h04a;

	typedef enum logic [2:0] {
		S_IDLE,
		S_SEND,
		S_IFG,
		S_BACKOFF,
		S_JAM,
		S_SILENT
	} spm_tx_e;

endpackage

// >>> hdl/spm_buf2.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock, an active-low asynchronous reset and a freezing clock enable.
 */
module spm_buf2 #(
	parameter int W = 10
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic cke_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} spm_buf_s;

	spm_buf_s q;
	spm_buf_s d;
	logic push;
	logic pop;

	// Ready depends only on the fill level, so the source never sees a
	// combinational path from the drain side.
	assign in_ready_out = (q.cnt != 2'h2);
	assign out_valid_out = (q.cnt != 2'h0);
	assign out_data_out = q.mem[q.rp];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data_in;
			d.wp = ~q.wp;
		end
		if (pop) begin
			d.rp = ~q.rp;
		end
		d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= '0;
		end else if (cke_in) begin
			q <= d;
		end
	end

endmodule

// >>> hdl/spm_port_mac.sv
/*
 * Per-port MAC transmit scheduler, receive filter and flow control.
 * Assumes the PHY gives one byte tick per transmitted byte on this clock,
 * and that carrier and collision arrive as asynchronous pins.
 */
module spm_port_mac #(
	parameter int STORM_CYC_100_P = spm_pkg::STORM_CYC_100,
	parameter int STORM_CYC_10_P = spm_pkg::STORM_CYC_10,
	parameter int BP_HOLD_CYC_P = spm_pkg::BP_HOLD_CYC,
	parameter int FREE_W = 10,
	parameter logic [FREE_W-1:0] FC_OFF_THR = 10'h040
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic cke_in,
	input wire logic full_duplex_in,
	input wire logic speed100_in,
	input wire logic aggr_backoff_en_in,
	input wire logic no_excess_drop_in,
	input wire logic bp_en_in,
	input wire logic max1536_en_in,
	input wire logic jumbo_en_in,
	input wire logic storm_en_in,
	input wire logic storm_mcast_in,
	input wire logic storm_limit_wr_in,
	input wire logic [10:0] storm_limit_in,
	input wire logic mac_carrier_detect_in,
	input wire logic collision_in,
	input wire logic tx_byte_tick_in,
	output logic mac_tx_frame_enable_out,
	output logic tx_preamble_only_out,
	output logic tx_ctrl_frame_out,
	output logic [15:0] tx_pause_time_out,
	input wire logic tx_frm_valid_in,
	input wire logic [11:0] tx_frm_len_in,
	output logic tx_frm_done_out,
	output logic tx_frm_drop_out,
	output logic tx_paused_out,
	input wire logic dest_busy_in,
	input wire logic rxq_full_in,
	input wire logic [FREE_W-1:0] free_bufs_in,
	output logic fc_active_out,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_last_in,
	output logic rx_out_valid_out,
	input wire logic rx_out_ready_in,
	output logic [7:0] rx_out_data_out,
	output logic rx_out_last_out,
	output logic rx_out_bad_out
);
	import spm_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic cs0;
		logic cs1;
		logic col0;
		logic col1;
		spm_tx_e st;
		logic [19:0] tmr;
		logic [19:0] hold;
		logic [4:0] att;
		logic [11:0] bcnt;
		logic ctrl;
		logic colgap;
		logic [15:0] lfsr;
		logic [15:0] pause;
		logic [19:0] quant;
		logic [15:0] fc_time;
		logic fc_act;
		logic pend_on;
		logic pend_off;
		logic [11:0] rcnt;
		logic [15:0] sh;
		logic bc;
		logic mc;
		logic vlan;
		logic mctl;
		logic pse;
		logic [15:0] pval;
		logic [22:0] ivl;
		logic [10:0] scnt;
		logic [10:0] slim;
		logic done;
		logic drop;
		logic en;
		logic pre;
	} spm_state_s;

	localparam spm_state_s RST_S = '{st: S_IDLE, lfsr: LFSR_SEED,
		slim: STORM_LIMIT_RST, default: '0};

	spm_state_s q;
	spm_state_s d;
	logic fire;
	logic bad;
	logic buf_ready;
	logic [9:0] buf_last_bad;

	assign fire = rx_valid_in && buf_ready;
	assign rx_ready_out = buf_ready;
	assign mac_tx_frame_enable_out = q.en;
	assign tx_preamble_only_out = q.pre;
	assign tx_ctrl_frame_out = q.ctrl;
	assign tx_pause_time_out = q.fc_time;
	assign tx_frm_done_out = q.done;
	assign tx_frm_drop_out = q.drop;
	assign tx_paused_out = (q.pause != PAUSE_ZERO);
	assign fc_active_out = q.fc_act;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [19:0] ifg;
		logic [19:0] slot;
		logic [11:0] len;
		logic [11:0] maxlen;
		logic [15:0] word;
		logic storm_hit;
		logic bp_act;
		logic act_set;
		logic [4:0] att_n;
		logic [4:0] k;
		logic [9:0] r;
		logic [11:0] tlen;
		ifg = speed100_in ? IFG_CYC_100 : IFG_CYC_10;
		slot = speed100_in ? SLOT_CYC_100 : SLOT_CYC_10;
		len = 12'(q.rcnt + 12'h001);
		word = {q.sh[7:0], rx_data_in};
		maxlen = jumbo_en_in ? MAX_JUMBO : (max1536_en_in ? MAX_1536 : MAX_STD);
		maxlen = 12'(maxlen + (q.vlan ? VLAN_EXTRA : 12'h000));
		storm_hit = storm_en_in && (q.bc || (storm_mcast_in && q.mc))
			&& (q.scnt >= q.slim);
		bp_act = q.fc_act && bp_en_in && !full_duplex_in;
		bad = rx_last_in && ((len < MIN_LEN) || (len > maxlen) || q.mctl
			|| storm_hit || bp_act);
		d = q;
		d.cs0 = mac_carrier_detect_in;
		d.cs1 = q.cs0;
		d.col0 = collision_in;
		d.col1 = q.col0;
		d.done = 1'b0;
		d.drop = 1'b0;
		d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};

		// ************************************************************
		// Pause timer, one count per 512 bit times
		// ************************************************************
		if (q.pause != PAUSE_ZERO) begin
			if (q.quant >= 20'(slot - 20'h00001)) begin
				d.quant = '0;
				d.pause = 16'(q.pause - 16'h0001);
			end else begin
				d.quant = 20'(q.quant + 20'h00001);
			end
		end

		// ************************************************************
		// Receive parse and filter
		// ************************************************************
		if (fire) begin
			d.sh = word;
			if (q.rcnt != 12'hfff) begin
				d.rcnt = len;
			end
			if (q.rcnt == '0) begin
				d.bc = (rx_data_in == BCAST_BYTE);
				d.mc = rx_data_in[0];
			end else if (q.rcnt <= POS_DA_END) begin
				d.bc = q.bc && (rx_data_in == BCAST_BYTE);
			end
			if (q.rcnt == POS_TYPE) begin
				d.mctl = (word == TYPE_CTRL);
				d.vlan = (word == TYPE_VLAN);
			end
			if (q.rcnt == POS_OPCODE) begin
				d.pse = q.mctl && (word == OP_PAUSE);
			end
			if (q.rcnt == POS_PTIME) begin
				d.pval = word;
			end
			if (rx_last_in) begin
				if (q.pse && (len >= MIN_LEN) && full_duplex_in) begin
					d.pause = q.pval;
					d.quant = '0;
				end
				if (storm_en_in && (q.bc || (storm_mcast_in && q.mc)) && !storm_hit) begin
					d.scnt = 11'(q.scnt + 11'h001);
				end
				d.rcnt = '0;
				d.bc = 1'b0;
				d.mc = 1'b0;
				d.vlan = 1'b0;
				d.mctl = 1'b0;
				d.pse = 1'b0;
			end
		end
		if (storm_limit_wr_in) begin
			d.slim = storm_limit_in;
		end
		if (q.ivl >= 23'((speed100_in ? STORM_CYC_100_P : STORM_CYC_10_P) - 1)) begin
			d.ivl = '0;
			d.scnt = '0;
		end else begin
			d.ivl = 23'(q.ivl + 23'h000001);
		end

		// ************************************************************
		// Flow control activation with hysteresis
		// ************************************************************
		act_set = (fire && rx_last_in && !bad && dest_busy_in) || rxq_full_in;
		if (!q.fc_act && act_set) begin
			d.fc_act = 1'b1;
			d.pend_on = full_duplex_in;
			d.pend_off = 1'b0;
		end else if (q.fc_act && !dest_busy_in && !rxq_full_in
			&& (free_bufs_in >= FC_OFF_THR)) begin
			d.fc_act = 1'b0;
			d.pend_off = full_duplex_in;
			d.pend_on = 1'b0;
		end

		// ************************************************************
		// Transmit scheduler
		// ************************************************************
		att_n = (q.att == 5'(EXCESS_COL - 5'h01)) ? 5'h00 : 5'(q.att + 5'h01);
		k = (att_n < (aggr_backoff_en_in ? AGGR_LIMIT : BACKOFF_LIMIT)) ? att_n
			: (aggr_backoff_en_in ? AGGR_LIMIT : BACKOFF_LIMIT);
		r = q.lfsr[9:0] & ~(10'h3ff << k);
		tlen = q.ctrl ? CTRL_LEN : tx_frm_len_in;
		case (q.st)
			S_IDLE: begin
				d.bcnt = '0;
				if (full_duplex_in && (q.pend_on || q.pend_off)) begin
					d.st = S_SEND;
					d.ctrl = 1'b1;
					d.fc_time = q.pend_on ? PAUSE_MAX : PAUSE_ZERO;
					d.pend_on = 1'b0;
					d.pend_off = 1'b0;
				end else if (tx_frm_valid_in && !(full_duplex_in && (q.pause != PAUSE_ZERO))
					&& (full_duplex_in || !q.cs1 || bp_act)) begin
					d.st = S_SEND;
					d.ctrl = 1'b0;
				end else if (bp_act) begin
					d.st = S_JAM;
					d.hold = '0;
				end
			end
			S_SEND: begin
				if (!full_duplex_in && q.col1) begin
					d.colgap = 1'b1;
					d.st = S_IFG;
					d.tmr = ifg;
					if (q.bcnt >= LATE_BYTES) begin
						d.drop = 1'b1;
						d.att = '0;
					end else if (att_n == '0 && !no_excess_drop_in) begin
						d.drop = 1'b1;
						d.att = '0;
					end else begin
						d.att = att_n;
						if (bp_act) begin
							d.st = S_JAM;
							d.hold = '0;
						end else begin
							d.st = S_BACKOFF;
							d.tmr = 20'(20'(r) * slot);
						end
					end
				end else if (tx_byte_tick_in) begin
					d.bcnt = 12'(q.bcnt + 12'h001);
					if (d.bcnt >= tlen) begin
						d.done = !q.ctrl;
						d.att = '0;
						d.ctrl = 1'b0;
						d.colgap = 1'b0;
						d.st = S_IFG;
						d.tmr = ifg;
					end
				end
			end
			S_IFG: begin
				if (q.colgap && q.cs1) begin
					d.tmr = ifg;
				end else if (q.tmr <= 20'h00001) begin
					d.st = S_IDLE;
					d.colgap = 1'b0;
				end else begin
					d.tmr = 20'(q.tmr - 20'h00001);
				end
			end
			S_BACKOFF: begin
				if (q.tmr == '0) begin
					d.st = S_IFG;
					d.tmr = ifg;
				end else begin
					d.tmr = 20'(q.tmr - 20'h00001);
				end
			end
			S_JAM: begin
				d.hold = 20'(q.hold + 20'h00001);
				if (!bp_act || tx_frm_valid_in) begin
					d.st = S_IFG;
					d.tmr = ifg;
					d.colgap = 1'b0;
				end else if (q.hold >= 20'(BP_HOLD_CYC_P - 1)) begin
					d.st = S_SILENT;
					d.tmr = ifg;
				end
			end
			S_SILENT: begin
				// The silence is kept to one gap, so the partner stays deferred.
				if (q.tmr <= 20'h00001) begin
					d.st = bp_act ? S_JAM : S_IDLE;
					d.hold = '0;
				end else begin
					d.tmr = 20'(q.tmr - 20'h00001);
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
		d.en = (d.st == S_SEND) || (d.st == S_JAM);
		d.pre = (d.st == S_JAM);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= RST_S;
		end else if (cke_in) begin
			q <= d;
		end
	end

	// ****************************************************************
	// Receive buffer toward the fabric
	// ****************************************************************
	spm_buf2 #(
		.W(10)
	) u_rx_buf (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.cke_in(cke_in),
		.in_valid_in(rx_valid_in),
		.in_ready_out(buf_ready),
		.in_data_in({rx_last_in, bad, rx_data_in}),
		.out_valid_out(rx_out_valid_out),
		.out_ready_in(rx_out_ready_in),
		.out_data_out(buf_last_bad)
	);

	assign rx_out_last_out = buf_last_bad[9];
	assign rx_out_bad_out = buf_last_bad[8];
	assign rx_out_data_out = buf_last_bad[7:0];

endmodule

// >>> test/spm_station.sv
/*
 * Remote station model: one byte tick per cycle (or every other cycle when
 * slow) while transmit is enabled, and a collision after a chosen byte count.
 * Assumes the bench clock and the active-low asynchronous reset.
 */
module spm_station (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic slow,
	input wire logic mac_tx_frame_enable_out,
	input wire logic [11:0] col_at,
	output logic tx_byte_tick_in,
	output logic collision_in,
	output logic mac_carrier_detect_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] n;
	// A collision holds until the port lets go of transmit, as a real jam would.
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			n <= '0;
			tx_byte_tick_in <= 1'b0;
			collision_in <= 1'b0;
		end else begin
			tx_byte_tick_in <= mac_tx_frame_enable_out && !(slow && tx_byte_tick_in);
			n <= mac_tx_frame_enable_out ? n + 12'(tx_byte_tick_in) : 12'h000;
			collision_in <= mac_tx_frame_enable_out && (collision_in || (col_at != 0 && n == col_at));
		end
	end
	assign mac_carrier_detect_in = collision_in;
endmodule

// >>> test/spm_port_mac_checker.sv
/*
 * Timing checks on the port MAC pins.
 * Assumes one clock domain and the active-low asynchronous reset.
 */
module spm_checker
	import spm_pkg::*;
#(
	parameter int FREE_W = 10,
	parameter logic [FREE_W-1:0] FC_OFF_THR = 10'h040
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic speed100_in,
	input wire logic full_duplex_in,
	input wire logic bp_en_in,
	input wire logic mac_tx_frame_enable_out,
	input wire logic tx_preamble_only_out,
	input wire logic tx_ctrl_frame_out,
	input wire logic [15:0] tx_pause_time_out,
	input wire logic tx_frm_done_out,
	input wire logic tx_frm_drop_out,
	input wire logic tx_paused_out,
	input wire logic rxq_full_in,
	input wire logic [FREE_W-1:0] free_bufs_in,
	input wire logic fc_active_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);
	// Ten low cycles at 100 Mb/s, split because repetitions stay short.
	ifg_gap_a: assert property (
		$fell(mac_tx_frame_enable_out) && speed100_in |-> !mac_tx_frame_enable_out [*8]
		##1 !mac_tx_frame_enable_out [*2]) else $error("gap too short");
	done_fall_a: assert property (
		tx_frm_done_out |-> $fell(mac_tx_frame_enable_out) ##1 !tx_frm_done_out)
		else $error("done not with enable fall");
	drop_once_a: assert property (
		tx_frm_drop_out |-> !mac_tx_frame_enable_out ##1 !tx_frm_drop_out)
		else $error("drop pulse wrong");
	pause_hold_a: assert property (
		$rose(mac_tx_frame_enable_out) && full_duplex_in && $past(tx_paused_out)
		|-> ##[0:1] tx_ctrl_frame_out) else $error("normal frame while paused");
	pause_val_a: assert property (
		$rose(tx_ctrl_frame_out) |-> tx_pause_time_out == (fc_active_out ? PAUSE_MAX : PAUSE_ZERO))
		else $error("pause time wrong");
	fc_all_a: assert property (
		rxq_full_in |-> ##[1:2] fc_active_out) else $error("queue full not flow controlled");
	fc_hyst_a: assert property (
		fc_active_out && free_bufs_in < FC_OFF_THR |=> fc_active_out)
		else $error("release under threshold");
	jam_pre_a: assert property (
		tx_preamble_only_out |-> mac_tx_frame_enable_out && !full_duplex_in && bp_en_in)
		else $error("preamble jam out of place");
endmodule

bind spm_port_mac spm_checker #(.FREE_W(FREE_W), .FC_OFF_THR(FC_OFF_THR)) chk_u (.*);

// >>> test/testbench.sv
/*
 * Self-checking bench for the port MAC: receive filtering, transmit spacing,
 * collisions, pause, flow control, back pressure and storm limiting.
 * Assumes the station model on the line side and shortened timer parameters.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import spm_pkg::*;
	logic sys_clk_in = 0, nrst_in = 0, cke_in = 1, full_duplex_in = 1, speed100_in = 1;
	logic aggr_backoff_en_in = 0, no_excess_drop_in = 0, bp_en_in = 0, max1536_en_in = 0;
	logic jumbo_en_in = 0, storm_en_in = 0, storm_mcast_in = 0, storm_limit_wr_in = 0;
	logic [10:0] storm_limit_in = 0;
	logic mac_carrier_detect_in, collision_in, tx_byte_tick_in, mac_tx_frame_enable_out;
	logic tx_preamble_only_out, tx_ctrl_frame_out, tx_frm_valid_in = 0, tx_frm_done_out;
	logic [15:0] tx_pause_time_out;
	logic [11:0] tx_frm_len_in = 8, col_at = 0;
	logic tx_frm_drop_out, tx_paused_out, dest_busy_in = 0, rxq_full_in = 0, fc_active_out;
	logic [9:0] free_bufs_in = 10'h3ff;
	logic rx_valid_in = 0, rx_ready_out, rx_last_in = 0, rx_out_valid_out, rx_out_ready_in = 1;
	logic [7:0] rx_data_in = 0, rx_out_data_out;
	logic rx_out_last_out, rx_out_bad_out, slow = 0, bad_q, refused = 0;
	int fails = 0, checks = 0, nf = 0, cyc = 0;

	spm_port_mac #(.STORM_CYC_100_P(200), .STORM_CYC_10_P(400), .BP_HOLD_CYC_P(50)) dut_u (.*);
	spm_station st_u (.*);

	always #50 sys_clk_in = ~sys_clk_in;
	// The fabric stalls one cycle in four, so the buffer fills and must refuse.
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		rx_out_ready_in <= #10 (cyc % 4 != 0);
		if (rx_valid_in && !rx_ready_out) refused <= 1;
		if (rx_out_valid_out && rx_out_ready_in && rx_out_last_out) begin
			bad_q <= rx_out_bad_out;
			nf <= nf + 1;
		end
	end

	task automatic step(int n = 1);
		repeat (n) @(posedge sys_clk_in);
		#10;
	endtask
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		for (int i = 0; i < lim && s !== 1'b1; i++) step();
	endtask
	task automatic send(int n, logic [15:0] ty, logic [15:0] w, logic bc, logic exp);
		int k;
		k = nf;
		for (int i = 0; i < n; i++) begin
			rx_valid_in = 1;
			rx_last_in = i == n - 1;
			rx_data_in = (i < 6 && bc) ? 8'hff : i == 12 ? ty[15:8] : i == 13 ? ty[7:0] :
				i == 14 ? 8'h00 : i == 15 ? 8'h01 : i == 16 ? w[15:8] : i == 17 ? w[7:0] : 8'(i);
			while (!rx_ready_out) step();
			step();
		end
		rx_valid_in = 0;
		for (int i = 0; i < 20 && nf == k; i++) step();
		chk(bad_q, exp);
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic t_len();
		int t[10][5] = '{'{63, 0, 0, 0, 1}, '{64, 0, 0, 0, 0}, '{1518, 0, 0, 0, 0},
			'{1519, 0, 0, 0, 1}, '{1536, 1, 0, 0, 0}, '{1537, 1, 0, 0, 1}, '{2048, 0, 1, 0, 0},
			'{2049, 0, 1, 0, 1}, '{1522, 0, 0, 1, 0}, '{1523, 0, 0, 1, 1}};
		for (int i = 0; i < 10; i++) begin
			max1536_en_in = t[i][1];
			jumbo_en_in = t[i][2];
			send(t[i][0], t[i][3] ? TYPE_VLAN : 16'h0800, 0, 0, t[i][4]);
		end
		chk(refused, 1);
	endtask
	task automatic t_tx();
		int g;
		tx_frm_valid_in = 1;
		wait_hi(tx_frm_done_out, 40);
		chk(tx_frm_done_out, 1);
		slow = 1;
		g = 0;
		while (!mac_tx_frame_enable_out && g < 200) begin
			g++;
			step();
		end
		chk(g >= IFG_CYC_100, 1);
		wait_hi(tx_frm_done_out, 40);
		tx_frm_valid_in = 0;
		chk(tx_frm_done_out, 1);
		slow = 0;
	endtask
	task automatic t_col();
		full_duplex_in = 0;
		col_at = 70;
		tx_frm_len_in = 100;
		tx_frm_valid_in = 1;
		wait_hi(tx_frm_drop_out, 150);
		tx_frm_valid_in = 0;
		chk(tx_frm_drop_out, 1);
		col_at = 5;
		step(20);
		tx_frm_valid_in = 1;
		wait_hi(collision_in, 40);
		col_at = 0;
		wait_hi(tx_frm_done_out, 400);
		tx_frm_valid_in = 0;
		chk(tx_frm_done_out, 1);
		// Aggressive backoff keeps sixteen early collisions within a few thousand cycles.
		aggr_backoff_en_in = 1;
		col_at = 3;
		step(20);
		tx_frm_valid_in = 1;
		wait_hi(tx_frm_drop_out, 8000);
		tx_frm_valid_in = 0;
		chk(tx_frm_drop_out, 1);
		col_at = 0;
		aggr_backoff_en_in = 0;
		tx_frm_len_in = 8;
		full_duplex_in = 1;
	endtask
	task automatic t_pause();
		send(64, TYPE_CTRL, 16'h0005, 0, 1);
		chk(tx_paused_out, 1);
		tx_frm_valid_in = 1;
		step(100);
		chk(mac_tx_frame_enable_out, 0);
		rxq_full_in = 1;
		wait_hi(tx_ctrl_frame_out, 5);
		chk(tx_ctrl_frame_out, 1);
		rxq_full_in = 0;
		send(64, TYPE_CTRL, PAUSE_ZERO, 0, 1);
		wait_hi(tx_frm_done_out, 200);
		tx_frm_valid_in = 0;
		chk(tx_frm_done_out, 1);
	endtask
	task automatic t_fc();
		dest_busy_in = 1;
		free_bufs_in = 10;
		send(64, 16'h0800, 0, 0, 0);
		wait_hi(tx_ctrl_frame_out, 20);
		chk(tx_pause_time_out, PAUSE_MAX);
		dest_busy_in = 0;
		step(100);
		chk(fc_active_out, 1);
		free_bufs_in = 10'h100;
		wait_hi(tx_ctrl_frame_out, 40);
		chk(tx_pause_time_out, PAUSE_ZERO);
		chk(fc_active_out, 0);
		step(80);
	endtask
	task automatic t_bp();
		full_duplex_in = 0;
		bp_en_in = 1;
		rxq_full_in = 1;
		wait_hi(fc_active_out, 5);
		chk(fc_active_out, 1);
		wait_hi(tx_preamble_only_out, 20);
		chk(tx_preamble_only_out, 1);
		rxq_full_in = 0;
		step(10);
		bp_en_in = 0;
		step(20);
		full_duplex_in = 1;
	endtask
	task automatic t_storm();
		storm_limit_in = 0;
		storm_limit_wr_in = 1;
		step();
		storm_limit_wr_in = 0;
		storm_en_in = 1;
		send(64, 16'h0800, 0, 1, 1);
		storm_en_in = 0;
		send(64, 16'h0800, 0, 1, 0);
	endtask

	initial begin
		step(2);
		nrst_in = 1;
		step();
		chk(rx_ready_out, 1);
		chk(fc_active_out, 0);
		t_len();
		t_tx();
		t_col();
		t_pause();
		t_fc();
		t_bp();
		t_storm();
		summarize();
	end
	// About three times the expected run of some twenty thousand cycles.
	initial begin
		#6000000;
		fails++;
		summarize();
	end
endmodule
